/* inc/ddf_pkg.sv */
package ddf_pkg;
  localparam int DQ_W = 8;
  localparam int WORD_W = 16;
  localparam int CA_W = 48;
  localparam int CA_CYC = 3;
  localparam int CA_RW = 47;
  localparam int CA_TGT = 46;
  localparam int CA_BURST = 45;
  localparam int CA_ROW_LSB = 16;
  localparam int CA_ROW_W = 22;
  localparam int CA_COL_W = 3;
  localparam int ADDR_W = CA_ROW_W + CA_COL_W;
  localparam int CYC_W = 8;
  localparam int LEN_W = 8;
  localparam int RD_LAT_DEF = 4;
  localparam int CORE_CLK_NS = 50;
  localparam int POR_US = 100;
  localparam int POR_CYC = (POR_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int SYSTEM_RESET_OUT_N_US = 1000;
  localparam int SYSTEM_RESET_OUT_N_CYC_DEF = (SYSTEM_RESET_OUT_N_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam logic [1:0] PH_HI = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_LO = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
endpackage

/* inc/ddf_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ddf_if;
  logic cs_n;
  logic ck;
  logic ck_c;
  logic shifted_strobe_clock;
  logic psc_c;
  logic [7:0] dq_h;
  logic dq_h_oe;
  logic [7:0] dq_d;
  logic dq_d_oe;
  logic read_data_strobe_o;
  logic read_data_strobe_oe;
  logic int_oe;
  logic system_reset_out_n_oe;
  logic reset_o;
  logic reset_oe;
  logic [7:0] dq;
  logic read_data_strobe;
  logic int_n;
  logic system_reset_out_n_n;
  logic reset_n;

  // Undriven lines settle low; open-drain lines and the reset input have pull-ups.
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
  assign read_data_strobe = read_data_strobe_oe ? read_data_strobe_o : 1'b0;
  assign int_n = ~int_oe;
  assign system_reset_out_n_n = ~system_reset_out_n_oe;
  assign reset_n = reset_oe ? reset_o : 1'b1;

  modport host (
    output cs_n, ck, ck_c, shifted_strobe_clock, psc_c, dq_h, dq_h_oe, reset_o, reset_oe,
    input dq, read_data_strobe, int_n, system_reset_out_n_n
  );
  modport dev (
    input cs_n, ck, ck_c, shifted_strobe_clock, psc_c, dq, reset_n,
    output dq_d, dq_d_oe, read_data_strobe_o, read_data_strobe_oe, int_oe, system_reset_out_n_oe
  );
endinterface
`default_nettype wire

/* core/ddf_dev.sv */
`timescale 1ns/1ns
`default_nettype none
module ddf_dev
#(
  parameter int RD_LAT = ddf_pkg::RD_LAT_DEF,
  parameter int MEM_AW = 8,
  parameter bit LOW_VOLT = 1'b1,
  parameter bit CENTER_ALIGNED_STROBE_OPTION = 1'b0,
  parameter int SYSTEM_RESET_OUT_N_CYC = ddf_pkg::SYSTEM_RESET_OUT_N_CYC_DEF
)
(
  // Core clock and internal power-on reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  ddf_if.dev link,
  // Event source
  input wire logic event_pulse,
  input wire logic int_clear,
  // Status
  output logic cmd_valid,
  output logic [ddf_pkg::CA_W-1:0] cmd_word,
  output logic standby,
  output logic int_pending
);
  import ddf_pkg::*;

  typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_READY} ddf_por_t;

  localparam logic [CYC_W-1:0] CA_END = CYC_W'(CA_CYC);
  localparam logic [CYC_W-1:0] CA_LAST = CYC_W'(CA_CYC - 1);
  localparam logic [CYC_W-1:0] LAUNCH_CYC = CYC_W'(CA_CYC + RD_LAT);
  localparam logic [31:0] POR_LAST = 32'(POR_CYC - 1);
  localparam logic [31:0] SYSTEM_RESET_OUT_N_LAST = 32'(SYSTEM_RESET_OUT_N_CYC - 1);

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  function automatic logic [MEM_AW-1:0] ca_addr(input logic [CA_W-1:0] ca);
    ca_addr = {ca[CA_ROW_LSB +: MEM_AW-CA_COL_W], ca[CA_COL_W-1:0]};
  endfunction

  // A wrapped burst stays inside its half-page of eight words.
  function automatic logic [MEM_AW-1:0] next_addr(input logic [MEM_AW-1:0] a, input logic lin);
    logic [CA_COL_W-1:0] col;
    col = a[CA_COL_W-1:0] + 3'h1;
    next_addr = lin ? a + 1'b1 : {a[MEM_AW-1:CA_COL_W], col};
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [CYC_W-1:0] cyc_r;
  logic [CA_W-1:0] ca_r;
  logic [DQ_W-1:0] hi_r;
  logic [MEM_AW-1:0] waddr_r;
  logic [MEM_AW-1:0] raddr_r;
  logic [WORD_W-1:0] rd_word_r;
  logic rd_oe_r;
  logic [CA_W-1:0] ca_hold_r;
  logic tog_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic rst_s1_r;
  logic rst_s2_r;
  ddf_por_t st_r;
  ddf_por_t st_nxt;
  logic [31:0] por_cnt_r;
  logic [31:0] por_cnt_nxt;
  logic system_reset_out_n_oe_r;
  logic standby_r;
  logic int_r;
  logic cmd_valid_r;
  logic [CA_W-1:0] cmd_word_r;

  // ----------------------------------------------------------------
  // Link-side decode
  // ----------------------------------------------------------------
  // Deselect, the reset pin or a device not yet in standby holds the
  // link logic in reset, so the next select fall always starts clean.
  wire link_rst = link.cs_n | ~link.reset_n | ~standby_r;
  wire [CA_W-1:0] ca_full = {ca_r[CA_W-WORD_W-1:0], hi_r, link.dq};
  wire ca_done = cyc_r >= CA_END;
  wire is_read = ca_done & ca_r[CA_RW];
  wire wr_en = ~link_rst & ca_done & ~ca_r[CA_RW];
  wire launch = is_read & (cyc_r >= LAUNCH_CYC);
  // On low-voltage parts the pair crossing is where the true clock
  // switches; the complement only qualifies it and is ignored otherwise.
  wire psc_ref = LOW_VOLT ? (link.shifted_strobe_clock & ~link.psc_c) : link.shifted_strobe_clock;
  wire read_data_strobe_ref = CENTER_ALIGNED_STROBE_OPTION ? psc_ref : link.ck;

  // ----------------------------------------------------------------
  // Falling clock edge: word assembly and write data
  // ----------------------------------------------------------------
  always_ff @(negedge link.ck or posedge link_rst)
  begin
    if (link_rst)
    begin
      cyc_r <= '0;
      ca_r <= '0;
      waddr_r <= '0;
    end
    else
    begin
      if (cyc_r != '1)
      begin
        cyc_r <= cyc_r + 1'b1;
      end
      if (!ca_done)
      begin
        ca_r <= ca_full;
      end
      if (cyc_r == CA_LAST)
      begin
        waddr_r <= ca_addr(ca_full);
      end
      else if (wr_en)
      begin
        waddr_r <= next_addr(waddr_r, 1'b1);
      end
    end
  end

  // The array has no reset: contents survive a hardware reset.
  always_ff @(negedge link.ck)
  begin
    if (wr_en)
    begin
      mem[waddr_r] <= {hi_r, link.dq};
    end
  end

  // Command hand-off to the core side survives deselect.
  always_ff @(negedge link.ck or negedge resetn)
  begin
    if (!resetn)
    begin
      ca_hold_r <= '0;
      tog_r <= 1'b0;
    end
    else if (cyc_r == CA_LAST)
    begin
      ca_hold_r <= ca_full;
      tog_r <= ~tog_r;
    end
  end

  // ----------------------------------------------------------------
  // Rising clock edge: high byte capture and read launch
  // ----------------------------------------------------------------
  always_ff @(posedge link.ck or posedge link_rst)
  begin
    if (link_rst)
    begin
      hi_r <= '0;
      raddr_r <= '0;
      rd_word_r <= '0;
      rd_oe_r <= 1'b0;
    end
    else
    begin
      hi_r <= link.dq;
      if (cyc_r == CA_END)
      begin
        raddr_r <= ca_addr(ca_r);
      end
      else if (launch)
      begin
        raddr_r <= next_addr(raddr_r, ca_r[CA_BURST]);
      end
      if (launch)
      begin
        rd_word_r <= mem[raddr_r];
      end
      rd_oe_r <= launch;
    end
  end

  // The byte mux follows the clock itself, so every data change sits on a link clock edge,
  // which is a strobe edge unless CENTER_ALIGNED_STROBE_OPTION is set, with no extra skew from a second flop stage.
  assign link.dq_d = link.ck ? rd_word_r[15:8] : rd_word_r[7:0];
  assign link.dq_d_oe = rd_oe_r;
  assign link.read_data_strobe_o = rd_oe_r & read_data_strobe_ref;
  assign link.read_data_strobe_oe = is_read;
  assign link.int_oe = int_r;
  assign link.system_reset_out_n_oe = system_reset_out_n_oe_r;

  // ----------------------------------------------------------------
  // Core side: synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
    end
    else
    begin
      tog_s1_r <= tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      rst_s1_r <= link.reset_n;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire cmd_seen = tog_s2_r ^ tog_s3_r;
  wire hw_rst = ~rst_s2_r;
  wire wr_event = cmd_seen & ~ca_hold_r[CA_RW];

  // ----------------------------------------------------------------
  // Core side: power-on reset sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    por_cnt_nxt = por_cnt_r + 32'h1;
    case (st_r)
      ST_POR:
      begin
        if (por_cnt_r == POR_LAST)
        begin
          st_nxt = ST_HOLD;
          por_cnt_nxt = '0;
        end
      end
      ST_HOLD:
      begin
        if (por_cnt_r == SYSTEM_RESET_OUT_N_LAST)
        begin
          st_nxt = ST_READY;
          por_cnt_nxt = '0;
        end
      end
      ST_READY:
      begin
        por_cnt_nxt = '0;
      end
      default:
      begin
        st_nxt = ST_POR;
        por_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ST_POR;
      por_cnt_r <= '0;
      system_reset_out_n_oe_r <= 1'b1;
      standby_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      por_cnt_r <= por_cnt_nxt;
      system_reset_out_n_oe_r <= st_nxt != ST_READY;
      standby_r <= st_nxt == ST_READY;
    end
  end

  // ----------------------------------------------------------------
  // Core side: events and command report
  // ----------------------------------------------------------------
  // A new event beats a clear in the same cycle; the reset pin wipes it.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_r <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_word_r <= '0;
    end
    else
    begin
      int_r <= ~hw_rst & (event_pulse | wr_event | (int_r & ~int_clear));
      cmd_valid_r <= cmd_seen & ~hw_rst;
      if (cmd_seen)
      begin
        cmd_word_r <= ca_hold_r;
      end
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_word = cmd_word_r;
  assign standby = standby_r;
  assign int_pending = int_r;
endmodule
`default_nettype wire

/* core/ddf_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ddf_host
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  ddf_if.host link,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic req_linear,
  input wire logic [ddf_pkg::ADDR_W-1:0] req_addr,
  input wire logic [ddf_pkg::LEN_W-1:0] req_len,
  // Write data
  input wire logic [ddf_pkg::WORD_W-1:0] wdata,
  output logic wdata_take,
  // Read data
  output logic [ddf_pkg::WORD_W-1:0] rdata,
  output logic rdata_valid,
  // Device pins seen by the system
  input wire logic hw_reset_req,
  output logic dev_int,
  output logic dev_system_reset_out_n
);
  import ddf_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_CA, H_WR, H_RD, H_END} ddf_hst_t;

  ddf_hst_t st_r;
  logic [1:0] ph_r;
  logic [LEN_W-1:0] cnt_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] rx_cnt_r;
  logic [CA_W-1:0] sh_r;
  logic rd_r;
  logic cs_n_r;
  logic ck_r;
  logic psc_r;
  logic [DQ_W-1:0] dq_r;
  logic dq_oe_r;
  logic take_r;
  logic [DQ_W-1:0] dq_s1_r;
  logic [DQ_W-1:0] dq_s2_r;
  logic read_data_strobe_s1_r;
  logic read_data_strobe_s2_r;
  logic read_data_strobe_s3_r;
  logic [2:0] irq_s_r;
  logic [2:0] rst_s_r;
  logic [DQ_W-1:0] rx_hi_r;
  logic [WORD_W-1:0] rdata_r;
  logic rdata_valid_r;
  logic req_ready_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [CA_W-1:0] ca_req;
  always_comb
  begin
    ca_req = '0;
    ca_req[CA_RW] = req_read;
    ca_req[CA_BURST] = req_linear;
    ca_req[CA_ROW_LSB +: CA_ROW_W] = req_addr[ADDR_W-1:CA_COL_W];
    ca_req[CA_COL_W-1:0] = req_addr[CA_COL_W-1:0];
  end

  wire start = (st_r == H_IDLE) & req_valid & (req_len != '0);
  wire last_ca = cnt_r == LEN_W'(CA_CYC - 1);
  wire last_wr = cnt_r == len_r - 1'b1;
  wire rx_rise = read_data_strobe_s2_r & ~read_data_strobe_s3_r;
  wire rx_fall = ~read_data_strobe_s2_r & read_data_strobe_s3_r;
  wire rx_done = rx_cnt_r == len_r;
  wire fall = ph_r == PH_FALL;

  // ----------------------------------------------------------------
  // Sequencer: four core cycles per link clock, data changes mid-phase
  // so it is centred on both clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= H_IDLE;
      ph_r <= PH_HI;
      cnt_r <= '0;
      len_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      cs_n_r <= 1'b1;
      ck_r <= 1'b0;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      take_r <= 1'b0;
      req_ready_r <= 1'b1;
    end
    else
    begin
      take_r <= 1'b0;
      if (st_r != H_IDLE)
      begin
        ph_r <= ph_r + 2'h1;
      end
      case (st_r)
        H_IDLE:
        begin
          ph_r <= PH_HI;
          if (start)
          begin
            cs_n_r <= 1'b0;
            sh_r <= ca_req;
            rd_r <= req_read;
            len_r <= req_len;
            cnt_r <= '0;
            st_r <= H_CA;
            req_ready_r <= 1'b0;
          end
        end
        H_CA, H_WR, H_RD:
        begin
          if (ph_r == PH_HI)
          begin
            dq_r <= sh_r[CA_W-1 -: DQ_W];
            dq_oe_r <= st_r != H_RD;
          end
          if (ph_r == PH_LO)
          begin
            dq_r <= sh_r[CA_W-DQ_W-1 -: DQ_W];
          end
          if (ph_r == PH_RISE)
          begin
            ck_r <= 1'b1;
          end
          if (fall)
          begin
            ck_r <= 1'b0;
            cnt_r <= cnt_r + 1'b1;
            sh_r <= {sh_r[CA_W-WORD_W-1:0], WORD_W'(0)};
            if (st_r == H_CA && last_ca)
            begin
              cnt_r <= '0;
              st_r <= rd_r ? H_RD : H_WR;
              if (!rd_r)
              begin
                sh_r <= {wdata, 32'h0};
                take_r <= 1'b1;
              end
            end
            else if (st_r == H_WR)
            begin
              if (last_wr)
              begin
                st_r <= H_END;
              end
              else
              begin
                sh_r <= {wdata, 32'h0};
                take_r <= 1'b1;
              end
            end
            else if (st_r == H_RD && rx_done)
            begin
              st_r <= H_END;
            end
          end
        end
        H_END:
        begin
          dq_oe_r <= 1'b0;
          if (fall)
          begin
            cs_n_r <= 1'b1;
            req_ready_r <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default:
        begin
          st_r <= H_IDLE;
          req_ready_r <= 1'b1;
        end
      endcase
    end
  end

  // Strobe clock trails the link clock by one core cycle, a quarter period;
  // it is parked low with its complement during writes.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      psc_r <= 1'b0;
    end
    else
    begin
      psc_r <= ck_r & rd_r;
    end
  end

  // ----------------------------------------------------------------
  // Read capture through synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      read_data_strobe_s1_r <= 1'b0;
      read_data_strobe_s2_r <= 1'b0;
      read_data_strobe_s3_r <= 1'b0;
      irq_s_r <= 3'h0;
      rst_s_r <= 3'h0;
      rx_hi_r <= '0;
      rx_cnt_r <= '0;
      rdata_r <= '0;
      rdata_valid_r <= 1'b0;
    end
    else
    begin
      dq_s1_r <= link.dq;
      dq_s2_r <= dq_s1_r;
      read_data_strobe_s1_r <= link.read_data_strobe;
      read_data_strobe_s2_r <= read_data_strobe_s1_r;
      read_data_strobe_s3_r <= read_data_strobe_s2_r;
      irq_s_r <= {irq_s_r[1:0], ~link.int_n};
      rst_s_r <= {rst_s_r[1:0], ~link.system_reset_out_n_n};
      rdata_valid_r <= 1'b0;
      if (start)
      begin
        rx_cnt_r <= '0;
      end
      else if (st_r == H_RD && !rx_done)
      begin
        if (rx_rise)
        begin
          rx_hi_r <= dq_s2_r;
        end
        if (rx_fall)
        begin
          rdata_r <= {rx_hi_r, dq_s2_r};
          rdata_valid_r <= 1'b1;
          rx_cnt_r <= rx_cnt_r + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.cs_n = cs_n_r;
  assign link.ck = ck_r;
  assign link.ck_c = ~ck_r;
  assign link.shifted_strobe_clock = psc_r;
  assign link.psc_c = rd_r & ~psc_r;
  assign link.dq_h = dq_r;
  assign link.dq_h_oe = dq_oe_r;
  assign link.reset_o = 1'b0;
  assign link.reset_oe = hw_reset_req;
  assign req_ready = req_ready_r;
  assign wdata_take = take_r;
  assign rdata = rdata_r;
  assign rdata_valid = rdata_valid_r;
  assign dev_int = irq_s_r[2];
  assign dev_system_reset_out_n = rst_s_r[2];
endmodule
`default_nettype wire

/* tb/ddf_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module ddf_asserts
#(
  parameter int SYSTEM_RESET_OUT_N_CYC = 20
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  input wire logic cs_n,
  input wire logic ck,
  input wire logic ck_c,
  input wire logic shifted_strobe_clock,
  input wire logic psc_c,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe,
  input wire logic read_data_strobe_oe,
  input wire logic system_reset_out_n_oe,
  input wire logic reset_n
);
  import ddf_pkg::*;
  // ----
  // Power-on window counter
  // ----
  // One cycle of slack each way covers where the count starts relative to the release edge.
  localparam int REL_LO = POR_CYC + SYSTEM_RESET_OUT_N_CYC - 1;
  localparam int REL_HI = POR_CYC + SYSTEM_RESET_OUT_N_CYC + 1;
  int por_cnt_r;
  int por_cnt_nxt;
  assign por_cnt_nxt = system_reset_out_n_oe ? por_cnt_r + 1 : por_cnt_r;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      por_cnt_r <= 0;
    else
      por_cnt_r <= por_cnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----
  // Properties
  // ----
  sel_start_a: assert property ($fell(cs_n) |-> !ck && ck_c)
    else $error("select fell outside the clock low phase");
  sel_end_a: assert property ($rose(cs_n) |-> !ck && ck_c)
    else $error("select rose outside the clock low phase");
  ck_pair_a: assert property (ck_c == !ck)
    else $error("clock pair not complementary");
  idle_quiet_a: assert property (cs_n && $past(cs_n) |-> !dq_d_oe && !read_data_strobe_oe)
    else $error("device drives while deselected");
  reset_float_a: assert property (!reset_n |-> !dq_d_oe && !read_data_strobe_oe)
    else $error("device drives during hardware reset");
  one_driver_a: assert property (!(dq_h_oe && dq_d_oe))
    else $error("both ends drive the data lines");
  shifted_pair_a: assert property (!(shifted_strobe_clock && psc_c))
    else $error("shifted clock pair both high");
  strobe_sel_a: assert property (read_data_strobe_oe |-> !cs_n && !$past(cs_n))
    else $error("strobe driven outside a selection");
  system_reset_out_n_time_a: assert property ($fell(system_reset_out_n_oe) |-> por_cnt_r >= REL_LO && por_cnt_r <= REL_HI)
    else $error("reset output released at the wrong time");
  system_reset_out_n_early_a: assert property (!system_reset_out_n_oe |-> por_cnt_r >= REL_LO)
    else $error("reset output low period too short");
endmodule
`default_nettype wire

/* tb/ddr_flash_signal_interface_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module ddr_flash_signal_interface_bench;
  import ddf_pkg::*;
  localparam int SYSTEM_RESET_OUT_N_T = 20;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid, req_read, req_linear, event_pulse, int_clear, hw_reset_req;
  logic req_ready, wdata_take, rdata_valid, dev_int, dev_system_reset_out_n, cmd_valid, standby, int_pending;
  logic [ADDR_W-1:0] req_addr;
  logic [LEN_W-1:0] req_len;
  logic [WORD_W-1:0] wdata, rdata, exp_rd;
  logic [CA_W-1:0] cmd_word, wire_ca, exp_ca;
  logic [WORD_W-1:0] mem_m [256];
  logic [CA_W-1:0] cmd_q [$];
  logic [WORD_W-1:0] rd_q [$];
  logic [31:0] k_r;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 25460;
  int ecnt = 0;
  int n_take = 0;
  wire logic [2:0] sigs;
  assign sigs = {standby, dev_int, req_ready};
  always #25 core_clk = ~core_clk;
  // ----
  // Both ends
  // ----
  ddf_if ddf_if_i ();
  ddf_host ddf_host_i (.core_clk(core_clk), .resetn(resetn), .link(ddf_if_i.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_linear(req_linear), .req_addr(req_addr),
    .req_len(req_len), .wdata(wdata), .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid),
    .hw_reset_req(hw_reset_req), .dev_int(dev_int), .dev_system_reset_out_n(dev_system_reset_out_n));
  ddf_dev #(.SYSTEM_RESET_OUT_N_CYC(SYSTEM_RESET_OUT_N_T), .CENTER_ALIGNED_STROBE_OPTION(1'b1)) ddf_dev_i (.core_clk(core_clk),
    .resetn(resetn), .link(ddf_if_i.dev), .event_pulse(event_pulse), .int_clear(int_clear),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .standby(standby), .int_pending(int_pending));
  ddf_asserts #(.SYSTEM_RESET_OUT_N_CYC(SYSTEM_RESET_OUT_N_T)) ddf_asserts_i (.core_clk(core_clk), .resetn(resetn),
    .cs_n(ddf_if_i.cs_n), .ck(ddf_if_i.ck), .ck_c(ddf_if_i.ck_c), .shifted_strobe_clock(ddf_if_i.shifted_strobe_clock), .psc_c(ddf_if_i.psc_c),
    .dq_h_oe(ddf_if_i.dq_h_oe), .dq_d_oe(ddf_if_i.dq_d_oe), .read_data_strobe_oe(ddf_if_i.read_data_strobe_oe),
    .system_reset_out_n_oe(ddf_if_i.system_reset_out_n_oe), .reset_n(ddf_if_i.reset_n));
  // ----
  // Tasks
  // ----
  task automatic check(input logic [CA_W-1:0] seen, input logic [CA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc;
    @(posedge core_clk);
    #2;
  endtask
  task automatic waitv(input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (sigs[b] !== v && k < lim)
    begin
      cyc;
      k++;
    end
    if (sigs[b] !== v)
    begin
      error_cnt++;
      complete_run;
    end
  endtask
  // The expected command word is built field by field, so a byte swap or a shifted field shows.
  task automatic req(input logic rdn, input logic lin, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n);
    cmd_q.push_back({rdn, 1'b0, lin, 7'h00, a[ADDR_W-1:3], 13'h0000, a[2:0]});
    req_read = rdn;
    req_linear = lin;
    req_addr = a;
    req_len = n;
    req_valid = 1'b1;
    cyc;
    req_valid = 1'b0;
    waitv(0, 1'b1, 400);
  endtask
  task automatic wr(input logic [7:0] lo);
    logic [31:0] r;
    r = $random(seed);
    wdata = r[15:0];
    mem_m[lo] = r[15:0];
    req(1'b0, 1'b0, {r[31:15], lo}, 8'h01);
  endtask
  task automatic rd(input logic lin, input logic [7:0] lo, input logic [7:0] n);
    logic [31:0] r;
    r = $random(seed);
    // A wrapped burst stays inside its group of eight words.
    for (int i = 0; i < n; i++)
      rd_q.push_back(mem_m[lin ? lo + i[7:0] : {lo[7:3], lo[2:0] + i[2:0]}]);
    req(1'b1, lin, {r[16:0], lo}, n);
  endtask
  // ----
  // Monitors
  // ----
  always @(negedge ddf_if_i.cs_n) ecnt = 0;
  always @(ddf_if_i.ck)
  begin
    if (ddf_if_i.cs_n === 1'b0 && ecnt < 2 * CA_CYC)
    begin
      wire_ca = {wire_ca[CA_W-9:0], ddf_if_i.dq};
      ecnt++;
    end
  end
  always @(posedge core_clk)
  begin
    if (cmd_valid === 1'b1)
    begin
      exp_ca = (cmd_q.size() > 0) ? cmd_q.pop_front() : 'x;
      check(cmd_word, exp_ca);
      check(wire_ca, exp_ca);
    end
    if (rdata_valid === 1'b1)
    begin
      exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
      check(rdata, exp_rd);
    end
    if (wdata_take === 1'b1)
      n_take++;
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    {req_valid, req_read, req_linear, event_pulse, int_clear, hw_reset_req} = 6'h00;
    req_addr = '0;
    req_len = '0;
    wdata = '0;
    repeat (20) @(posedge core_clk);
    #2 resetn = 1'b1;
    repeat (4) cyc;
    check(dev_system_reset_out_n, 1'b1);
    waitv(2, 1'b1, 2400);
    check(ddf_if_i.system_reset_out_n_oe, 1'b0);
    repeat (3) cyc;
    check(dev_system_reset_out_n, 1'b0);
    for (int i = 0; i < 8; i++)
      wr(8'h40 + i[7:0]);
    repeat (4)
    begin
      k_r = $random(seed);
      wr({5'h08, k_r[2:0]});
    end
    rd(1'b1, 8'h40, 8'h08);
    rd(1'b0, 8'h46, 8'h04);
    // Writes also raise the interrupt, so it is cleared before the event test.
    int_clear = 1'b1;
    cyc;
    int_clear = 1'b0;
    waitv(1, 1'b0, 20);
    check(ddf_if_i.int_n, 1'b1);
    event_pulse = 1'b1;
    cyc;
    event_pulse = 1'b0;
    waitv(1, 1'b1, 20);
    check(ddf_if_i.int_n, 1'b0);
    hw_reset_req = 1'b1;
    repeat (6) cyc;
    check(ddf_if_i.reset_n, 1'b0);
    check({ddf_if_i.dq_d_oe, ddf_if_i.read_data_strobe_oe}, 2'h0);
    hw_reset_req = 1'b0;
    repeat (6) cyc;
    check(int_pending, 1'b0);
    rd(1'b1, 8'h46, 8'h02);
    for (int k = 0; k < 100 && rd_q.size() + cmd_q.size() != 0; k++)
      cyc;
    check(rd_q.size() + cmd_q.size(), 0);
    check(n_take, 12);
    complete_run;
  end
endmodule
`default_nettype wire
